// File: rtl/genset_mode_and_event_log.sv
/*
 * Generator-set mode sequencer (stop, manual, auto) with a circular
 * alarm log, user indicator LEDs and a small register port.
 * Assumes a single 25 MHz clock, alarm conditions, timestamps and user
 * inputs already on that clock, and raw pins that need synchronising.
 */
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "genset_defs.svh"

module genset_mode_and_event_log
    import genset_pkg::*;
#(
    parameter int unsigned STOP_DLY_CYC = `STOP_DLY_S * `CLK_HZ,
    parameter int unsigned COOL_CYC     = `COOL_S * `CLK_HZ
)(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire pin_in_t     pins,
    input  wire logic [7:0]  alarm_cond,
    input  wire logic [95:0] user_in,
    input  wire logic [31:0] rtc_time,
    input  wire logic [31:0] run_hours,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic [31:0]      reg_rdata,
    output logic             fuel_out,
    output logic             load_req,
    output logic             irq,
    output logic [1:0]       led,
    output log_rec_t         view_rec
);

    state_t q;
    state_t nxt;

    // ----------------------------------------------------------------
    // derived terms
    // ----------------------------------------------------------------
    logic [7:0]   press;
    logic [7:0]   lvl;
    logic [7:0]   en_mask;
    logic         req;
    logic [127:0] led_src;
    logic [8:0]   rd_idx9;
    logic [7:0]   rd_idx;
    logic [31:0]  stamp_sel;

    // a change counts once the second and third stages agree
    assign lvl   = (q.s2 == q.s3) ? q.s3 : q.flt;
    assign press = lvl & ~q.flt;
    assign req   = lvl[`P_REMOTE] | ~lvl[`P_MAINS];
    // logged classes steered by the control register
    assign en_mask = (q.ctrl[`C_SHUT] ? `SHUT_MASK : 8'h00)
                   | (q.ctrl[`C_TRIP] ? `TRIP_MASK : 8'h00)
                   | (q.ctrl[`C_WARN] ? `WARN_MASK : 8'h00);
    assign stamp_sel = q.ctrl[`C_HOURS] ? run_hours : rtc_time;
    // newest record sits just below the write pointer
    assign rd_idx9 = {1'b0, q.wr_ptr} + `LOG_BACK9 - {1'b0, q.view};
    assign rd_idx  = (rd_idx9 >= `LOG_FULL9) ? 8'(rd_idx9 - `LOG_FULL9) : rd_idx9[7:0];
    assign led_src = {user_in, 8'h00, q.seq, q.mode, q.fuel, q.alat, lvl};

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [7:0] pop;
        logic [7:0] fresh;
        logic [2:0] pop_id;
        logic [2:0] clr;
        logic [2:0] ev;
        logic       found;
        pop    = 8'h00;
        fresh  = 8'h00;
        pop_id = 3'h0;
        clr    = 3'h0;
        ev     = 3'h0;
        found  = 1'b0;
        nxt    = q;

        // three-stage pin synchroniser
        nxt.s1  = pins;
        nxt.s2  = q.s1;
        nxt.s3  = q.s2;
        nxt.flt = lvl;

        // mode buttons, stop first
        if (press[`P_STOP])
        begin
            nxt.mode = MODE_STOP;
            nxt.alat = q.alat & alarm_cond;
        end
        else if (press[`P_MANUAL])
        begin
            nxt.mode = MODE_MANUAL;
            nxt.load = 1'b0;
        end
        else if (press[`P_AUTO])
        begin
            nxt.mode = MODE_AUTO;
            nxt.load = 1'b0;
        end
        if (nxt.mode != q.mode)
        begin
            ev[`I_MODE] = 1'b1;
        end

        // run sequence per mode
        case (q.mode)
            MODE_STOP:
            begin
                nxt.seq  = SEQ_IDLE;
                nxt.fuel = 1'b0;
                nxt.load = 1'b0;
            end
            MODE_MANUAL:
            begin
                if (press[`P_START])
                begin
                    nxt.seq  = SEQ_RUN;
                    nxt.fuel = 1'b1;
                end
                else if (q.seq == SEQ_RUN && lvl[`P_ENG] && lvl[`P_REMOTE])
                begin
                    nxt.load = 1'b1;
                end
                else if (q.seq != SEQ_RUN)
                begin
                    nxt.seq = q.fuel ? SEQ_RUN : SEQ_IDLE;
                end
            end
            MODE_AUTO:
            begin
                case (q.seq)
                    SEQ_IDLE:
                    begin
                        if (req)
                        begin
                            nxt.seq  = SEQ_RUN;
                            nxt.fuel = 1'b1;
                        end
                    end
                    SEQ_RUN:
                    begin
                        nxt.fuel = 1'b1;
                        if (!req)
                        begin
                            nxt.seq = SEQ_DELAY;
                            nxt.tmr = 32'(STOP_DLY_CYC);
                        end
                        else if (lvl[`P_ENG])
                        begin
                            nxt.load = 1'b1;
                        end
                    end
                    SEQ_DELAY:
                    begin
                        nxt.tmr = 32'(q.tmr - 32'h1);
                        if (req)
                        begin
                            nxt.seq = SEQ_RUN;
                        end
                        else if (q.tmr == 32'h0)
                        begin
                            nxt.seq  = SEQ_COOL;
                            nxt.load = 1'b0;
                            nxt.tmr  = 32'(COOL_CYC);
                        end
                    end
                    SEQ_COOL:
                    begin
                        nxt.tmr = 32'(q.tmr - 32'h1);
                        if (req)
                        begin
                            nxt.seq = SEQ_RUN;
                        end
                        else if (q.tmr == 32'h0)
                        begin
                            nxt.seq  = SEQ_IDLE;
                            nxt.fuel = 1'b0;
                        end
                    end
                    default:
                    begin
                        nxt.seq = SEQ_IDLE;
                    end
                endcase
            end
            default:
            begin
                nxt.mode = MODE_STOP;
            end
        endcase

        // latched shutdowns stop the set, trips drop the load
        if (|(q.alat & `SHUT_MASK))
        begin
            nxt.fuel = 1'b0;
            nxt.load = 1'b0;
            nxt.seq  = SEQ_IDLE;
        end
        if (|(q.alat & `TRIP_MASK))
        begin
            nxt.load = 1'b0;
        end

        // latch new alarms and queue the enabled ones
        fresh    = alarm_cond & ~q.alat;
        nxt.alat = nxt.alat | alarm_cond;
        for (int i = 0; i < 8; i++)
        begin
            if (q.pend[i] && !found)
            begin
                found  = 1'b1;
                pop_id = 3'(i);
                pop[i] = 1'b1;
            end
        end
        nxt.pend = (q.pend & ~pop) | (fresh & en_mask);

        // write one queued alarm per cycle, oldest overwritten when full
        if (found)
        begin
            nxt.log[q.wr_ptr] = '{alarm_id: pop_id, hours: q.ctrl[`C_HOURS], stamp: stamp_sel};
            nxt.wr_ptr = (q.wr_ptr == `LOG_LAST) ? 8'h00 : 8'(q.wr_ptr + 8'h01);
            ev[`I_LOGGED] = 1'b1;
            if (q.cnt == `LOG_FULL)
            begin
                ev[`I_OVWR] = 1'b1;
            end
            else
            begin
                nxt.cnt = 8'(q.cnt + 8'h01);
            end
        end

        // down press walks to older records, wrapping to the newest
        if (press[`P_DOWN] && q.cnt != 8'h00)
        begin
            nxt.view = (8'(q.view + 8'h01) >= q.cnt) ? 8'h00 : 8'(q.view + 8'h01);
        end
        nxt.view_rec = q.log[rd_idx];

        // indicator LEDs
        nxt.led[0] = led_src[q.ledsel[6:0]];
        nxt.led[1] = led_src[q.ledsel[13:7]];

        // register writes
        if (reg_we)
        begin
            case (reg_addr)
                `A_CTRL:   nxt.ctrl   = reg_wdata[3:0];
                `A_ISTAT:  clr        = reg_wdata[2:0];
                `A_IMASK:  nxt.imask  = reg_wdata[2:0];
                `A_LEDSEL: nxt.ledsel = reg_wdata[13:0];
                default:   nxt.ctrl   = q.ctrl;
            endcase
        end
        // set wins over a clear in the same cycle
        nxt.istat = (q.istat & ~clr) | ev;
        nxt.irq   = |(q.istat & q.imask);

        // register reads, data valid the cycle after the strobe
        nxt.rdata = 32'h0;
        if (reg_re)
        begin
            case (reg_addr)
                `A_CTRL:    nxt.rdata = {28'h0, q.ctrl};
                `A_STAT:    nxt.rdata = {q.view[4:0], q.cnt, q.alat, q.load, q.fuel, 2'h0, q.seq, q.mode}; // low view bits
                `A_ISTAT:   nxt.rdata = {29'h0, q.istat};
                `A_IMASK:   nxt.rdata = {29'h0, q.imask};
                `A_LEDSEL:  nxt.rdata = {18'h0, q.ledsel};
                `A_VIEW_ID: nxt.rdata = {28'h0, q.view_rec.hours, q.view_rec.alarm_id};
                `A_VIEW_TS: nxt.rdata = q.view_rec.stamp;
                default:    nxt.rdata = 32'h0;
            endcase
        end

        if (sys_rst)
        begin
            nxt      = '0;
            nxt.mode = MODE_STOP;
            nxt.seq  = SEQ_IDLE;
            nxt.ctrl = `CTRL_RST;
        end
    end

    // ----------------------------------------------------------------
    // state register and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        q <= nxt;
    end

    assign reg_rdata = q.rdata;
    assign fuel_out  = q.fuel;
    assign load_req  = q.load;
    assign irq       = q.irq;
    assign led       = q.led;
    assign view_rec  = q.view_rec;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_cnt_max;
        @(posedge sys_clk) disable iff (sys_rst) q.cnt <= `LOG_FULL;
    endproperty
    a_cnt_max: assert property (p_cnt_max) else $error("log count above depth");

    property p_overwrite;
        @(posedge sys_clk) disable iff (sys_rst)
        (q.cnt == `LOG_FULL && q.pend != 8'h00) |=> (q.cnt == `LOG_FULL && q.istat[`I_OVWR]
            && q.wr_ptr != $past(q.wr_ptr));
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("full log did not overwrite");

    property p_warn_skip;
        @(posedge sys_clk) disable iff (sys_rst)
        (!q.ctrl[`C_WARN] && q.pend == 8'h00 && (alarm_cond & ~`WARN_MASK) == 8'h00) |=> q.pend == 8'h00;
    endproperty
    a_warn_skip: assert property (p_warn_skip) else $error("disabled class was queued");

    property p_stamp;
        @(posedge sys_clk) disable iff (sys_rst)
        (q.pend != 8'h00) |=> q.log[$past(q.wr_ptr)].stamp == $past(stamp_sel);
    endproperty
    a_stamp: assert property (p_stamp) else $error("record stamp wrong");

    property p_view_wrap;
        @(posedge sys_clk) disable iff (sys_rst)
        (press[`P_DOWN] && q.cnt != 8'h00 && 8'(q.view + 8'h01) == q.cnt) |=> q.view == 8'h00;
    endproperty
    a_view_wrap: assert property (p_view_wrap) else $error("view did not wrap");

    property p_stop_clear;
        @(posedge sys_clk) disable iff (sys_rst)
        press[`P_STOP] |=> q.alat == $past(alarm_cond);
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear gone alarms");

    property p_stop_load;
        @(posedge sys_clk) disable iff (sys_rst) q.mode == MODE_STOP |=> !q.load;
    endproperty
    a_stop_load: assert property (p_stop_load) else $error("load held in stop");

    property p_stop_fuel;
        @(posedge sys_clk) disable iff (sys_rst) q.mode == MODE_STOP |=> !q.fuel;
    endproperty
    a_stop_fuel: assert property (p_stop_fuel) else $error("fuel on in stop");

    property p_stop_remote;
        @(posedge sys_clk) disable iff (sys_rst)
        (q.mode == MODE_STOP && !press[`P_MANUAL] && !press[`P_AUTO]) [*2] |=> q.seq == SEQ_IDLE;
    endproperty
    a_stop_remote: assert property (p_stop_remote) else $error("engine started in stop");

    property p_man_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        (q.mode == MODE_MANUAL && q.load && press[2:0] == 3'h0 && q.alat == 8'h00) |=> q.load;
    endproperty
    a_man_hold: assert property (p_man_hold) else $error("manual load dropped");

    property p_one_mode;
        @(posedge sys_clk) disable iff (sys_rst) $onehot(q.mode);
    endproperty
    a_one_mode: assert property (p_one_mode) else $error("mode not one-hot");

    property p_led;
        @(posedge sys_clk) disable iff (sys_rst)
        $stable(q.ledsel) |=> q.led[0] == $past(led_src[q.ledsel[6:0]]);
    endproperty
    a_led: assert property (p_led) else $error("led source mismatch");

endmodule

`default_nettype wire

// File: rtl/genset_defs.svh
/*
 * Constants of the generator-set mode sequencer and event log:
 * register offsets, field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef GENSET_DEFS_SVH
`define GENSET_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ       25000000
`define STOP_DLY_S   5
`define COOL_S       60

// ----------------------------------------------------------------
// event log geometry
// ----------------------------------------------------------------
`define LOG_DEPTH    250
`define LOG_LAST     8'hF9
`define LOG_FULL     8'hFA
`define LOG_FULL9    9'h0FA
`define LOG_BACK9    9'h0F9

// ----------------------------------------------------------------
// alarm classes (one bit per alarm source)
// ----------------------------------------------------------------
`define SHUT_MASK    8'h0F
`define TRIP_MASK    8'h30
`define WARN_MASK    8'hC0

// ----------------------------------------------------------------
// pin bit positions inside the synchroniser vectors
// ----------------------------------------------------------------
`define P_STOP       0
`define P_MANUAL     1
`define P_AUTO       2
`define P_START      3
`define P_DOWN       4
`define P_REMOTE     5
`define P_MAINS      6
`define P_ENG        7

// ----------------------------------------------------------------
// register map (byte addresses) and fields
// ----------------------------------------------------------------
`define A_CTRL       8'h00
`define A_STAT       8'h04
`define A_ISTAT      8'h08
`define A_IMASK      8'h0C
`define A_LEDSEL     8'h10
`define A_VIEW_ID    8'h14
`define A_VIEW_TS    8'h18
`define CTRL_RST     4'h3
`define C_SHUT       0
`define C_TRIP       1
`define C_WARN       2
`define C_HOURS      3
`define I_LOGGED     0
`define I_MODE       1
`define I_OVWR       2
`define LED_SRC_ST   8'h20

`endif

// File: rtl/genset_pkg.sv
/*
 * Types of the generator-set mode sequencer and event log.
 * Assumes genset_defs.svh is on the include path.
 */
`include "genset_defs.svh"

package genset_pkg;

    // operating mode, exactly one bit set
    typedef enum logic [2:0] {
        MODE_STOP   = 3'b001,
        MODE_MANUAL = 3'b010,
        MODE_AUTO   = 3'b100
    } mode_t;

    // engine run sequence
    typedef enum logic [3:0] {
        SEQ_IDLE  = 4'b0001,
        SEQ_RUN   = 4'b0010,
        SEQ_DELAY = 4'b0100,
        SEQ_COOL  = 4'b1000
    } seq_t;

    // pins from outside, stop button in bit 0
    typedef struct packed {
        logic eng_run;
        logic mains_ok;
        logic remote_start;
        logic btn_down;
        logic btn_start;
        logic btn_auto;
        logic btn_manual;
        logic btn_stop;
    } pin_in_t;

    // one log record
    typedef struct packed {
        logic [2:0]  alarm_id;
        logic        hours;
        logic [31:0] stamp;
    } log_rec_t;

    // whole state of the block
    typedef struct packed {
        logic [7:0]                      s1;
        logic [7:0]                      s2;
        logic [7:0]                      s3;
        logic [7:0]                      flt;
        mode_t                           mode;
        seq_t                            seq;
        logic [31:0]                     tmr;
        logic [7:0]                      alat;
        logic [7:0]                      pend;
        log_rec_t [`LOG_DEPTH-1:0]       log;
        logic [7:0]                      wr_ptr;
        logic [7:0]                      cnt;
        logic [7:0]                      view;
        log_rec_t                        view_rec;
        logic [3:0]                      ctrl;
        logic [2:0]                      istat;
        logic [2:0]                      imask;
        logic [13:0]                     ledsel;
        logic [1:0]                      led;
        logic                            fuel;
        logic                            load;
        logic                            irq;
        logic [31:0]                     rdata;
    } state_t;

endpackage

// File: rtl/dummy_unused_none.sv
/*
 * Holds no logic; all of the block lives in the principal design file.
 * Assumes nothing of its surroundings.
 */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: bench/genset_engine_model.sv
/*
 * Engine model for the generator-set sequencer: runs while fuel is on.
 * Assumes the bench clock and the block's synchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none

module genset_engine_model (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic fuel_out,
    output logic      eng_run
);
    logic [2:0] spin_ff;

    // engine speeds up a few cycles after fuel and comes to rest without it
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            spin_ff <= 3'h0;
        else
            spin_ff <= {spin_ff[1:0], fuel_out};
    end
    assign eng_run = spin_ff[2];
endmodule

`default_nettype wire

// File: bench/genset_mode_and_event_log_tb_top.sv
/*
 * Self-checking bench of the mode sequencer and event log.
 * Assumes the design files under rtl/ and the engine model beside it.
 */
`timescale 1ns/1ns
`default_nettype none
`include "genset_defs.svh"

module genset_mode_and_event_log_tb_top
    import genset_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] btn = 5'h0;
    logic remote = 1'b0;
    logic mains = 1'b1;
    logic [7:0] alarm_cond = 8'h00;
    logic [31:0] rtc_time = 32'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [31:0] reg_rdata;
    logic fuel_out, load_req, irq, eng_w;
    logic [1:0] led;
    log_rec_t view_rec;
    pin_in_t pins_w;
    int err_total = 0;
    int tests_run = 0;

    assign pins_w = {eng_w, mains, remote, btn};
    always #20 sys_clk = ~sys_clk;

    genset_mode_and_event_log #(.STOP_DLY_CYC(10), .COOL_CYC(20)) genset_mode_and_event_log_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .pins(pins_w), .alarm_cond(alarm_cond),
        .user_in(96'h1), .rtc_time(rtc_time), .run_hours(32'h00000ABC), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .fuel_out(fuel_out), .load_req(load_req), .irq(irq), .led(led), .view_rec(view_rec));
    genset_engine_model genset_engine_model_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .fuel_out(fuel_out), .eng_run(eng_w));

    // ----------------------------------------------------------------
    // bus, pin and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_we <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk);
        reg_we <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_re <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        #1 chk(reg_rdata & m, exp);
    endtask
    task automatic press(input int b);
        @(posedge sys_clk);
        btn[b] <= 1'b1;
        repeat (5) @(posedge sys_clk);
        btn[b] <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic log_one(input int stamp, input logic [7:0] cond);
        @(posedge sys_clk);
        rtc_time <= 32'(stamp); alarm_cond <= cond;
        repeat (4) @(posedge sys_clk);
        alarm_cond <= cond & 8'hC0;
        press(`P_STOP);
    endtask
    task automatic outs(input logic f, input logic l);
        #1 chk({30'h0, fuel_out, load_req}, {30'h0, f, l});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog well past the expected run length
    initial
    begin
        #(60000 * 40);
        err_total++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rchk(`A_CTRL, 32'hF, 32'h3);
        rchk(`A_STAT, 32'h7, 32'h1);
        rchk(8'h40, 32'hFFFFFFFF, 32'h0);
        $display("test reset done");
        wr(`A_LEDSEL, 32'h1010); // led0 from fuel, led1 from user_in[0]
        press(`P_MANUAL);
        rchk(`A_STAT, 32'h7, 32'h2);
        press(`P_START);
        outs(1'b1, 1'b0);
        chk({30'h0, led}, 32'h3);
        @(posedge sys_clk);
        remote <= 1'b1;
        repeat (10) @(posedge sys_clk);
        outs(1'b1, 1'b1);
        @(posedge sys_clk);
        remote <= 1'b0;
        repeat (10) @(posedge sys_clk);
        outs(1'b1, 1'b1);
        press(`P_STOP);
        outs(1'b0, 1'b0);
        rchk(`A_STAT, 32'h7, 32'h1);
        @(posedge sys_clk);
        remote <= 1'b1;
        repeat (20) @(posedge sys_clk);
        outs(1'b0, 1'b0);
        $display("test stop and manual done");
        press(`P_AUTO);
        repeat (10) @(posedge sys_clk);
        outs(1'b1, 1'b1);
        @(posedge sys_clk);
        remote <= 1'b0;
        repeat (20) @(posedge sys_clk);
        outs(1'b1, 1'b0);
        repeat (25) @(posedge sys_clk);
        outs(1'b0, 1'b0);
        // mains failure alone is a start request in auto
        @(posedge sys_clk);
        mains <= 1'b0;
        repeat (20) @(posedge sys_clk);
        outs(1'b1, 1'b1);
        press(`P_STOP);
        mains <= 1'b1;
        $display("test auto done");
        wr(`A_IMASK, 32'h1);
        log_one(1, 8'h41);
        rchk(`A_ISTAT, 32'h1, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(`A_ISTAT, 32'h7);
        repeat (2) @(posedge sys_clk);
        #1 chk({31'h0, irq}, 32'h0);
        log_one(2, 8'h42);
        rchk(`A_STAT, 32'h07F80000, 32'h00100000);
        rchk(`A_STAT, 32'h0007F800, 32'h00020000);
        chk({28'h0, view_rec.alarm_id, view_rec.hours}, 32'h2);
        rchk(`A_VIEW_TS, 32'hFFFFFFFF, 32'h2);
        press(`P_DOWN);
        #1 chk(view_rec.stamp, 32'h1);
        press(`P_DOWN);
        #1 chk(view_rec.stamp, 32'h2);
        $display("test log view done");
        for (int i = 3; i <= 252; i++)
            log_one(i, 8'h01);
        rchk(`A_STAT, 32'h07F80000, 32'h07D00000);
        rchk(`A_ISTAT, 32'h4, 32'h4);
        #1 chk(view_rec.stamp, 32'd252);
        repeat (249) press(`P_DOWN);
        #1 chk(view_rec.stamp, 32'd3);
        press(`P_DOWN);
        #1 chk(view_rec.stamp, 32'd252);
        // warnings on, shutdowns off, running-hours stamp
        wr(`A_CTRL, 32'hC);
        log_one(253, 8'h41);
        rchk(`A_STAT, 32'h07F80000, 32'h07D00000);
        chk({28'h0, view_rec.alarm_id, view_rec.hours}, 32'hD);
        chk(view_rec.stamp, 32'h00000ABC);
        press(`P_DOWN);
        #1 chk(view_rec.stamp, 32'd252);
        $display("test log full done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
